// ---- sep_map.vh ----
// Constants for the state-event timer and PWM unit
`ifndef SEP_MAP_VH
`define SEP_MAP_VH

`define SEP_N_IN        8
`define SEP_N_OUT       10
`define SEP_N_EV        16
`define SEP_N_MC        16
`define SEP_N_ST        32
`define SEP_N_IO        18
`define SEP_IO_W        5
`define SEP_ST_W        5
`define SEP_MC_IDX_W    4
`define SEP_CNT_W       32
`define SEP_HALF_W      16

// Select field positions inside the io index
`define SEP_IO_OUT_BASE 5'h08

// I/O condition codes
`define SEP_IOC_LOW     2'h0
`define SEP_IOC_RISE    2'h1
`define SEP_IOC_FALL    2'h2
`define SEP_IOC_HIGH    2'h3

// Combination codes
`define SEP_CMB_OR      2'h0
`define SEP_CMB_MATCH   2'h1
`define SEP_CMB_IO      2'h2
`define SEP_CMB_AND     2'h3

// Direction qualifier codes
`define SEP_DQ_ANY      2'h0
`define SEP_DQ_UP       2'h1
`define SEP_DQ_DOWN     2'h2

// Reset values
`define SEP_RST_STATE   5'h00
`define SEP_RST_CNT     32'h0000_0000
`define SEP_RST_OUT     10'h000

`endif

// ---- sep_event.v ----
// One event evaluator: match, io condition, direction and state qualifiers
`timescale 1ns/1ps
`include "sep_map.vh"

module sep_event (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_match,
  input  wire [17:0] i_io_lvl,
  input  wire [17:0] i_io_rise,
  input  wire [17:0] i_io_fall,
  input  wire [4:0]  i_io_sel,
  input  wire [1:0]  i_io_cond,
  input  wire [1:0]  i_comb,
  input  wire [1:0]  i_dir_qual,
  input  wire        i_bidir,
  input  wire        i_down,
  input  wire        i_match_hold,
  input  wire        i_limit,
  input  wire [31:0] i_state_msk,
  input  wire [4:0]  i_state,
  output wire        o_fire
);

  reg  hold_q;
  reg  io_ok;
  wire match_eff;
  wire dir_ok;
  wire st_ok;
  reg  cond;

  // Held match stays armed until the event fires or the counter limits
  assign match_eff = i_match | hold_q; // R13

  always @* begin
    io_ok = 1'b0;
    if (i_io_sel < `SEP_N_IO) begin
      case (i_io_cond)
        `SEP_IOC_LOW:  io_ok = ~i_io_lvl[i_io_sel];
        `SEP_IOC_RISE: io_ok = i_io_rise[i_io_sel];
        `SEP_IOC_FALL: io_ok = i_io_fall[i_io_sel];
        default:       io_ok = i_io_lvl[i_io_sel];
      endcase
    end
  end

  always @* begin
    case (i_comb) // R04
      `SEP_CMB_MATCH: cond = match_eff;
      `SEP_CMB_IO:    cond = io_ok;
      `SEP_CMB_AND:   cond = match_eff & io_ok;
      default:        cond = match_eff | io_ok;
    endcase
  end

  // Qualifier ignored in up-only mode
  assign dir_ok = ~i_bidir | (i_dir_qual == `SEP_DQ_ANY) |
                  ((i_dir_qual == `SEP_DQ_UP) & ~i_down) |
                  ((i_dir_qual == `SEP_DQ_DOWN) & i_down); // R12
  assign st_ok  = i_state_msk[i_state]; // R14
  assign o_fire = cond & dir_ok & st_ok;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_q <= 1'b0;
    end else if (o_fire | i_limit | ~i_match_hold) begin
      hold_q <= 1'b0;
    end else if (i_match) begin
      hold_q <= 1'b1; // R13
    end
  end

endmodule // sep_event

// ---- sep_timer.v ----
// State-event timer and PWM unit: counters, events, outputs, captures, states
`timescale 1ns/1ps
`include "sep_map.vh"

// Operation
// R01: One 32-bit or two 16-bit counters, up or up/down
// R02: Eight inputs, ten outputs, sixteen events, thirty-two states
// R03: Counter clocked by system clock or input
// R04: Event from match, io edge/level, or combination
// R05: Actions follow events directly in hardware
// R06: Events start, stop or halt counter
// R07: Limit clears up-only, reverses up/down
// R08: Events set, clear or toggle outputs
// R09: Event copies count into assigned capture registers
// R10: Events raise interrupt or DMA requests
// R11: Match register zero as automatic limit
// R12: Events qualified by count direction
// R13: Match may be held until qualified
// R14: Event enabled only in assigned states
// R15: Event loads its target state
// R16: State kept across counter wrap and limit
// R17: Ten single-edge PWM outputs, shared cycle
// R18: Stop restartable; halt waits for software clear
module sep_timer (
  input  wire          i_clk,
  input  wire          i_sys_rst,
  input  wire [7:0]    i_in,
  input  wire          i_unify,
  input  wire [1:0]    i_bidir,
  input  wire [1:0]    i_ckin_en,
  input  wire [5:0]    i_ckin_sel,
  input  wire [1:0]    i_auto_limit,
  input  wire [1:0]    i_run_set,
  input  wire [1:0]    i_halt_clr,
  input  wire [15:0]   i_mc_is_cap,
  input  wire [511:0]  i_match_val,
  input  wire [255:0]  i_cap_ev,
  input  wire [15:0]   i_ev_hctr,
  input  wire [79:0]   i_ev_io_sel,
  input  wire [31:0]   i_ev_io_cond,
  input  wire [31:0]   i_ev_comb,
  input  wire [31:0]   i_ev_dir_qual,
  input  wire [63:0]   i_ev_match_sel,
  input  wire [15:0]   i_ev_match_hold,
  input  wire [511:0]  i_ev_state_msk,
  input  wire [15:0]   i_ev_state_ld,
  input  wire [79:0]   i_ev_next_state,
  input  wire [15:0]   i_start_ev,
  input  wire [15:0]   i_stop_ev,
  input  wire [15:0]   i_halt_ev,
  input  wire [15:0]   i_limit_ev,
  input  wire [159:0]  i_out_set,
  input  wire [159:0]  i_out_clr,
  input  wire [15:0]   i_irq_ev,
  input  wire [15:0]   i_dma0_ev,
  input  wire [15:0]   i_dma1_ev,
  output wire [9:0]    o_out,
  output wire [31:0]   o_count,
  output wire [511:0]  o_cap_val,
  output wire [4:0]    o_state_l,
  output wire [4:0]    o_state_h,
  output wire [1:0]    o_running,
  output wire [1:0]    o_halted,
  output wire [1:0]    o_down,
  output wire [15:0]   o_event,
  output wire          o_irq,
  output wire [1:0]    o_dma_req
);

  reg  [31:0]  cnt_q;
  reg  [31:0]  cnt_d;
  reg  [1:0]   dir_q;
  reg  [1:0]   dir_d;
  reg  [1:0]   run_q;
  reg  [1:0]   halt_q;
  reg  [4:0]   st_q [0:1];
  reg  [4:0]   st_d [0:1];
  reg  [9:0]   out_q;
  reg  [17:0]  io_prev_q;
  reg  [511:0] cap_q;
  reg  [15:0]  event_q;
  reg          irq_q;
  reg  [1:0]   dma_q;

  wire [17:0]  io_lvl;
  wire [17:0]  io_rise;
  wire [17:0]  io_fall;
  wire [15:0]  match_l;
  wire [15:0]  match_h;
  wire [15:0]  fire;
  wire [15:0]  on_h;
  wire [15:0]  fire_k [0:1];
  wire [1:0]   lim;
  wire [1:0]   tick;
  wire [1:0]   limit_k;
  wire [32:0]  step_u;
  wire [32:0]  step_l;
  wire [32:0]  step_h;
  integer      e;
  integer      k;

  // Step one counter; narrow counters keep only the low half
  function [32:0] step;
    input [31:0] c;
    input        d;
    input        l;
    input        b;
    input        w;
    begin
      if (l && !b) begin
        step = {1'b0, 32'h0000_0000}; // R07
      end else if (l && b) begin
        step = d ? {1'b0, c + 32'h0000_0001} : {1'b1, c - 32'h0000_0001}; // R07
      end else if (d && (c == 32'h0000_0000)) begin
        step = {1'b0, 32'h0000_0001};
      end else begin
        step = d ? {1'b1, c - 32'h0000_0001} : {1'b0, c + 32'h0000_0001};
      end
      if (!w) begin
        step[31:16] = 16'h0000;
      end
    end
  endfunction

  assign io_lvl  = {out_q, i_in};
  assign io_rise = io_lvl & ~io_prev_q;
  assign io_fall = ~io_lvl & io_prev_q;

  // Match compare per register; capture registers never match
  genvar j;
  generate
    for (j = 0; j < `SEP_N_MC; j = j + 1) begin : g_mc
      wire [31:0] mv = i_match_val[j*32 +: 32];
      assign match_l[j] = ~i_mc_is_cap[j] &
                          (i_unify ? (cnt_q == mv) : (cnt_q[15:0] == mv[15:0]));
      assign match_h[j] = ~i_mc_is_cap[j] & ~i_unify & (cnt_q[31:16] == mv[31:16]);

      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          cap_q[j*32 +: 32] <= `SEP_RST_CNT;
        end else if (i_mc_is_cap[j] && |(fire & i_cap_ev[j*16 +: 16])) begin
          cap_q[j*32 +: 32] <= cnt_q; // R09
        end
      end
    end
  endgenerate

  // In unified mode every event belongs to the low counter
  assign on_h      = i_ev_hctr & {16{~i_unify}};
  assign fire_k[0] = fire & ~on_h;
  assign fire_k[1] = fire & on_h;

  assign lim[0] = |(fire_k[0] & i_limit_ev) | (i_auto_limit[0] & match_l[0]); // R07 R11
  assign lim[1] = |(fire_k[1] & i_limit_ev) | (i_auto_limit[1] & match_h[0]); // R07 R11

  generate
    for (j = 0; j < `SEP_N_EV; j = j + 1) begin : g_ev
      wire [3:0] msel = i_ev_match_sel[j*4 +: 4];
      wire       hi   = on_h[j];
      sep_event u_event (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_match      (hi ? match_h[msel] : match_l[msel]),
        .i_io_lvl     (io_lvl),
        .i_io_rise    (io_rise),
        .i_io_fall    (io_fall),
        .i_io_sel     (i_ev_io_sel[j*5 +: 5]),
        .i_io_cond    (i_ev_io_cond[j*2 +: 2]),
        .i_comb       (i_ev_comb[j*2 +: 2]),
        .i_dir_qual   (i_ev_dir_qual[j*2 +: 2]),
        .i_bidir      (hi ? i_bidir[1] : i_bidir[0]),
        .i_down       (hi ? dir_q[1] : dir_q[0]),
        .i_match_hold (i_ev_match_hold[j]),
        .i_limit      (hi ? lim[1] : lim[0]),
        .i_state_msk  (i_ev_state_msk[j*32 +: 32]),
        .i_state      (hi ? st_q[1] : st_q[0]),
        .o_fire       (fire[j])
      );
    end
  endgenerate

  // Input clock option: count on rising edge of the chosen input
  assign tick[0] = run_q[0] & ~halt_q[0] & (~i_ckin_en[0] | io_rise[i_ckin_sel[2:0]]); // R03
  assign tick[1] = run_q[1] & ~halt_q[1] & ~i_unify &
                   (~i_ckin_en[1] | io_rise[i_ckin_sel[5:3]]); // R03
  assign limit_k = lim;

  assign step_u = step(cnt_q, dir_q[0], limit_k[0], i_bidir[0], 1'b1);
  assign step_l = step({16'h0000, cnt_q[15:0]}, dir_q[0], limit_k[0], i_bidir[0], 1'b0);
  assign step_h = step({16'h0000, cnt_q[31:16]}, dir_q[1], limit_k[1], i_bidir[1], 1'b0);

  always @* begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (i_unify) begin
      if (tick[0]) begin
        cnt_d    = step_u[31:0]; // R01
        dir_d[0] = step_u[32] & i_bidir[0];
      end
    end else begin
      if (tick[0]) begin
        cnt_d[15:0] = step_l[15:0]; // R01
        dir_d[0]    = step_l[32] & i_bidir[0];
      end
      if (tick[1]) begin
        cnt_d[31:16] = step_h[15:0];
        dir_d[1]     = step_h[32] & i_bidir[1];
      end
    end
  end

  // Last event with a state load wins; state is untouched by limit
  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      st_d[k] = st_q[k]; // R16
      for (e = 0; e < `SEP_N_EV; e = e + 1) begin
        if (fire_k[k][e] && i_ev_state_ld[e]) begin
          st_d[k] = i_ev_next_state[e*5 +: 5]; // R15
        end
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q     <= `SEP_RST_CNT;
      dir_q     <= 2'h0;
      st_q[0]   <= `SEP_RST_STATE;
      st_q[1]   <= `SEP_RST_STATE;
      io_prev_q <= {`SEP_RST_OUT, i_in}; // No false edge from pins already high at reset
    end else begin
      cnt_q     <= cnt_d;
      dir_q     <= dir_d;
      st_q[0]   <= st_d[0];
      st_q[1]   <= st_d[1];
      io_prev_q <= io_lvl;
    end
  end

  // Run control; halt freezes until software clears it and beats that clear; stop beats start
  generate
    for (j = 0; j < 2; j = j + 1) begin : g_run
      wire start_e = |(fire_k[j] & i_start_ev);
      wire stop_e  = |(fire_k[j] & i_stop_ev);
      wire halt_e  = |(fire_k[j] & i_halt_ev);

      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          halt_q[j] <= 1'b0;
          run_q[j]  <= 1'b0;
        end else begin
          if (halt_e) begin
            halt_q[j] <= 1'b1; // R06
          end else if (i_halt_clr[j]) begin
            halt_q[j] <= 1'b0; // R18
          end
          if (halt_e || stop_e) begin
            run_q[j] <= 1'b0; // R06
          end else if ((start_e || i_run_set[j]) && !halt_q[j]) begin
            run_q[j] <= 1'b1; // R18
          end
        end
      end
    end
  endgenerate

  // Set and clear from one event together toggle; each output has its own duty
  generate
    for (j = 0; j < `SEP_N_OUT; j = j + 1) begin : g_out
      wire set_e = |(fire & i_out_set[j*16 +: 16]);
      wire clr_e = |(fire & i_out_clr[j*16 +: 16]);

      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          out_q[j] <= 1'b0;
        end else if (set_e && clr_e) begin
          out_q[j] <= ~out_q[j]; // R08
        end else if (set_e) begin
          out_q[j] <= 1'b1; // R08 R17
        end else if (clr_e) begin
          out_q[j] <= 1'b0; // R08 R17
        end
      end
    end
  endgenerate

  // Requests are registered one cycle after the firing event
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      event_q <= 16'h0000;
      irq_q   <= 1'b0;
      dma_q   <= 2'h0;
    end else begin
      event_q <= fire; // R05
      irq_q   <= |(fire & i_irq_ev); // R10
      dma_q   <= {|(fire & i_dma1_ev), |(fire & i_dma0_ev)}; // R10
    end
  end

  assign o_out     = out_q; // R02
  assign o_count   = cnt_q;
  assign o_cap_val = cap_q;
  assign o_state_l = st_q[0];
  assign o_state_h = st_q[1];
  assign o_running = run_q;
  assign o_halted  = halt_q;
  assign o_down    = dir_q;
  assign o_event   = event_q;
  assign o_irq     = irq_q;
  assign o_dma_req = dma_q;

endmodule // sep_timer

// ---- sep_timer_assertions.sv ----
// Port-level checks for the state-event timer
`timescale 1ns/1ps
module sep_timer_assertions (
  input logic         i_clk,
  input logic         i_sys_rst,
  input logic         i_unify,
  input logic [1:0]   i_bidir,
  input logic [1:0]   i_ckin_en,
  input logic [1:0]   i_auto_limit,
  input logic [511:0] i_match_val,
  input logic [15:0]  i_ev_state_ld,
  input logic [79:0]  i_ev_next_state,
  input logic [15:0]  i_halt_ev,
  input logic [15:0]  i_limit_ev,
  input logic [159:0] i_out_set,
  input logic [159:0] i_out_clr,
  input logic [15:0]  i_irq_ev,
  input logic [15:0]  i_dma0_ev,
  input logic [15:0]  i_dma1_ev,
  input logic [9:0]   o_out,
  input logic [31:0]  o_count,
  input logic [4:0]   o_state_l,
  input logic [1:0]   o_running,
  input logic [1:0]   o_halted,
  input logic [1:0]   o_down,
  input logic [15:0]  o_event,
  input logic         o_irq,
  input logic [1:0]   o_dma_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_up_tick;
    i_unify && o_running[0] && !i_ckin_en[0] && !i_bidir[0] && !i_auto_limit[0];
  endsequence
  // Top of an up/down sweep with match zero as the limit
  sequence s_top_up;
    i_unify && i_bidir[0] && i_auto_limit[0] && o_running[0] && !o_down[0] && !i_ckin_en[0]
      && o_count == i_match_val[31:0];
  endsequence
  a_irq_from_event: assert property (o_irq == |(o_event & $past(i_irq_ev)))
    else $error("irq pulse wrong");
  a_dma_from_event: assert property (o_dma_req[0] == |(o_event & $past(i_dma0_ev)) &&
    o_dma_req[1] == |(o_event & $past(i_dma1_ev))) else $error("dma request wrong");
  a_out_set_high: assert property (|(o_event & $past(i_out_set[15:0])) && !(|(o_event & $past(i_out_clr[15:0])))
    |-> o_out[0]) else $error("output 0 not set");
  a_halt_stops: assert property (i_unify && |(o_event & $past(i_halt_ev)) |-> o_halted[0] && !o_running[0])
    else $error("halt event did not halt");
  a_halt_holds: assert property ($past(o_halted[0]) && o_halted[0] |-> !o_running[0])
    else $error("halted counter running");
  a_stop_frozen: assert property (i_unify && !o_running[0] |=> $stable(o_count))
    else $error("stopped counter moved");
  a_up_count: assert property (s_up_tick ##1 !(|(o_event & $past(i_limit_ev))) |-> o_count == $past(o_count) + 32'h1)
    else $error("up count step wrong");
  a_limit_clear: assert property (s_up_tick ##1 |(o_event & $past(i_limit_ev)) |-> o_count == 32'h0)
    else $error("limit did not clear");
  a_limit_turn: assert property (s_top_up |=> o_down[0] && o_count == $past(o_count) - 32'h1)
    else $error("limit did not reverse");
  a_state_hold: assert property (o_event == 16'h0 |-> $stable(o_state_l))
    else $error("state moved without event");
  a_state_load: assert property (i_unify && o_event == 16'h2 && $past(i_ev_state_ld[1])
    |-> o_state_l == $past(i_ev_next_state[9:5])) else $error("state not loaded");
endmodule // sep_timer_assertions

bind sep_timer sep_timer_assertions chk_u (.*);

// ---- sep_pins.sv ----
// Pin-side model driving the eight timer inputs
`timescale 1ns/1ps
module sep_pins (
  input  wire       i_clk,
  input  wire [7:0] i_pat,
  output reg  [7:0] o_in
);
  // Pins move on the falling edge, well away from sampling
  initial o_in = 8'h00;
  always @(negedge i_clk) begin
    o_in <= i_pat;
  end
endmodule // sep_pins

// ---- testbench.sv ----
// Self-checking bench for the state-event timer
`timescale 1ns/1ps
`include "sep_map.vh"
module testbench;
  logic         i_clk = 1'b0, i_sys_rst = 1'b1, i_unify;
  logic [7:0]   pat = 8'h00;
  logic [1:0]   i_bidir, i_ckin_en, i_auto_limit, i_run_set, i_halt_clr;
  logic [5:0]   i_ckin_sel;
  logic [15:0]  i_mc_is_cap, i_ev_hctr, i_ev_match_hold, i_ev_state_ld, i_start_ev, i_stop_ev;
  logic [15:0]  i_halt_ev, i_limit_ev, i_irq_ev, i_dma0_ev, i_dma1_ev;
  logic [511:0] i_match_val, i_ev_state_msk;
  logic [255:0] i_cap_ev;
  logic [79:0]  i_ev_io_sel, i_ev_next_state;
  logic [31:0]  i_ev_io_cond, i_ev_comb, i_ev_dir_qual;
  logic [63:0]  i_ev_match_sel;
  logic [159:0] i_out_set, i_out_clr;
  wire  [7:0]   i_in;
  wire  [9:0]   o_out;
  wire  [31:0]  o_count;
  wire  [511:0] o_cap_val;
  wire  [4:0]   o_state_l, o_state_h;
  wire  [1:0]   o_running, o_halted, o_down, o_dma_req;
  wire  [15:0]  o_event;
  wire          o_irq;
  logic [26:0]  notes[$];
  logic [26:0]  exp;
  int           fails = 0, comparisons = 0, seed = 65936, m, c, up, np;

  sep_timer dut_u (.*);
  sep_pins pins_u (.i_clk(i_clk), .i_pat(pat), .o_in(i_in));

  always #20 i_clk = ~i_clk;

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task cfg_reset;
    {i_bidir, i_ckin_en, i_ckin_sel, i_auto_limit, i_run_set, i_halt_clr, i_mc_is_cap, i_ev_hctr, i_ev_match_hold} = '0;
    {i_ev_state_ld, i_start_ev, i_stop_ev, i_halt_ev, i_limit_ev, i_irq_ev, i_dma0_ev, i_dma1_ev} = '0;
    {i_match_val, i_ev_state_msk, i_cap_ev, i_ev_io_sel, i_ev_next_state, i_ev_io_cond} = '0;
    {i_ev_comb, i_ev_dir_qual, i_ev_match_sel, i_out_set, i_out_clr} = '0;
    i_unify = 1'b1;
    i_sys_rst = 1'b1;
    tick(4);
    i_sys_rst = 1'b0;
  endtask

  task pulse_run;
    i_run_set = 2'b01;
    tick(1);
    i_run_set = 2'b00;
  endtask

  // Bounded wait for every predicted event to show up
  task wait_idle;
    for (int k = 0; k < 60 && notes.size() != 0; k++) tick(1);
    check(notes.size(), 0);
  endtask

  always @(posedge i_clk) begin
    #1;
    if (o_event !== 16'h0) begin
      exp = (notes.size() != 0) ? notes.pop_front() : 27'h0;
      check({o_irq, o_event, o_out}, exp);
    end
  end

  initial begin
    #200000;
    fails++;
    give_verdict;
  end

  initial begin
    cfg_reset;
    tick(1);
    check({o_out, o_count[15:0], o_state_l, o_running, o_halted, o_down}, 40'h0);
    // Event 0: match 5 limits, stops, sets out 0; event 1: pin 2 rise toggles, captures, loads
    i_match_val[31:0] = 32'h5;
    i_mc_is_cap = 16'h0002;
    i_ev_comb[1:0] = `SEP_CMB_MATCH;
    i_ev_state_msk[31:0] = '1;
    {i_limit_ev, i_stop_ev, i_irq_ev, i_dma0_ev} = {4{16'h0001}};
    i_out_set[15:0] = 16'h0003;
    i_out_clr[15:0] = 16'h0002;
    i_ev_io_sel[9:5] = 5'h02;
    i_ev_io_cond[3:2] = `SEP_IOC_RISE;
    i_ev_comb[3:2] = `SEP_CMB_IO;
    i_ev_state_msk[63:32] = 32'h1;
    i_ev_state_ld = 16'h0002;
    i_ev_next_state[9:5] = 5'h07;
    i_cap_ev[31:16] = 16'h0002;
    notes.push_back({1'b0, 16'h0002, 10'h001});
    notes.push_back({1'b1, 16'h0001, 10'h001});
    pulse_run;
    pat <= 8'h04;
    wait_idle;
    check(o_cap_val[63:32], 32'h1);
    check(o_state_l, 5'h07);
    check({o_running[0], o_count}, 40'h0);
    // Second rise lands in a state outside event 1's set
    pat <= 8'h00;
    tick(2);
    pat <= 8'h04;
    tick(4);
    check(o_out, 10'h001);
    notes.push_back({1'b1, 16'h0001, 10'h001});
    pulse_run;
    check(o_running[0], 1'b1);
    wait_idle;
    check(o_state_l, 5'h07);
    // Event 2: pin 5 rise halts the counter
    i_ev_io_sel[14:10] = 5'h05;
    i_ev_io_cond[5:4] = `SEP_IOC_RISE;
    i_ev_comb[5:4] = `SEP_CMB_IO;
    i_ev_state_msk[95:64] = '1;
    i_halt_ev = 16'h0004;
    notes.push_back({1'b0, 16'h0004, 10'h001});
    pulse_run;
    pat <= 8'h24;
    wait_idle;
    check(o_halted[0], 1'b1);
    pulse_run;
    tick(1);
    check(o_running[0], 1'b0);
    i_halt_clr = 2'b01;
    tick(1);
    i_halt_clr = 2'b00;
    check(o_halted, 2'b00);
    notes.push_back({1'b1, 16'h0001, 10'h001});
    pulse_run;
    wait_idle;
    // Up/down sweep, match zero as limit, event 3 only on the way down
    cfg_reset;
    i_bidir = 2'b01;
    i_auto_limit = 2'b01;
    m = 4 + ($random(seed) & 7);
    i_match_val[63:0] = {32'h2, m[31:0]};
    i_ev_match_sel[15:12] = 4'h1;
    i_ev_comb[7:6] = `SEP_CMB_MATCH;
    i_ev_dir_qual[7:6] = `SEP_DQ_DOWN;
    i_ev_state_msk[127:96] = '1;
    i_out_set[31:16] = 16'h0008;
    notes.push_back({1'b0, 16'h0008, 10'h002});
    pulse_run;
    c = 0;
    up = 1;
    repeat (2 * m + 4) begin
      tick(1);
      if (up && c == m) {c, up} = {m - 1, 0};
      else if (!up && c == 0) {c, up} = {1, 1};
      else c = up ? c + 1 : c - 1;
      check(o_count, c[31:0]);
    end
    wait_idle;
    check(o_down[0], 1'b0);
    // Split counters: low counts pin 0 rises, high limits at 3; event 5 needs its held match
    cfg_reset;
    i_unify = 1'b0;
    i_ckin_en = 2'b01;
    i_auto_limit = 2'b10;
    i_match_val[63:0] = {32'h2, 32'h0003_ffff};
    i_ev_hctr = 16'h0010;
    i_ev_comb[11:8] = {`SEP_CMB_AND, `SEP_CMB_MATCH};
    i_ev_match_sel[23:20] = 4'h1;
    i_ev_io_sel[29:25] = 5'h01;
    i_ev_io_cond[11:10] = `SEP_IOC_HIGH;
    i_ev_match_hold = 16'h0020;
    i_ev_state_msk[191:128] = '1;
    {i_ev_state_ld, i_stop_ev, i_dma1_ev} = {3{16'h0010}};
    i_ev_next_state[24:20] = 5'h09;
    i_out_set[63:32] = {16'h0020, 16'h0010};
    i_irq_ev = 16'h0020;
    notes.push_back({1'b0, 16'h0010, 10'h004});
    notes.push_back({1'b1, 16'h0020, 10'h00c});
    i_run_set = 2'b11;
    tick(1);
    i_run_set = 2'b00;
    np = 4 + ($random(seed) & 7);
    for (int p = 0; p < np; p++) begin
      pat <= (p < 3) ? 8'h01 : 8'h03;
      tick(2);
      pat <= (p < 3) ? 8'h00 : 8'h02;
      tick(2);
    end
    wait_idle;
    check(o_count, {16'h0000, np[15:0]});
    check({o_state_h, o_state_l}, 10'h120);
    check(o_running, 2'b01);
    give_verdict;
  end
endmodule // testbench
